//--- mem_pin_pkg.sv
// Constants, field layouts and enumerations for the narrow memory pin control.
// Assumes a single 200 MHz core clock and a plain strobe register port.

package mem_pin_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] CFG_ADDR = 4'h0;
  localparam logic [3:0] CMD_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CFG_W = 6;
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_DIV_MSB = 1;
  localparam int CFG_WIDE_BIT = 2;
  localparam int CFG_TYPE_LSB = 3;
  localparam int CFG_TYPE_MSB = 4;
  localparam int CFG_RSEL_BIT = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

  localparam int CMD_W = 5;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_A0_BIT = 1;
  localparam int CMD_HALF_BIT = 2;
  localparam int CMD_COL_BIT = 3;
  localparam int CMD_PDT_BIT = 4;
  localparam logic [CMD_W-1:0] CMD_RESET = 5'h00;

  localparam int STAT_W = 6;

  // ------------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {SRC_EXT = 2'h0, SRC_DIV4 = 2'h1, SRC_DIV6 = 2'h2} clk_src_t;
  typedef enum logic [1:0] {DIV_BY1 = 2'h0, DIV_BY2 = 2'h1, DIV_BY4 = 2'h2} div_ratio_t;
  typedef enum logic [1:0] {MT_ASYNC = 2'h0, MT_SDRAM = 2'h1, MT_SYNC = 2'h2} mem_type_t;
  typedef enum logic [1:0] {ACC_IDLE = 2'h0, ACC_STROBE = 2'h1, ACC_RECOVER = 2'h3} acc_state_t;

  // ------------------------------------------------------------------
  // Timing counts (core clock cycles / interface clock ticks)
  // ------------------------------------------------------------------
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV4_HIGH = 3'h2;
  localparam logic [2:0] DIV6_LAST = 3'h5;
  localparam logic [2:0] DIV6_HIGH = 3'h3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [1:0] STROBE_TICKS = 2'h2;

endpackage

//--- narrow_ext_mem_pin_control.sv
// Pin-level control of a 16-bit external memory port: interface clock
// selection, two output clocks, shared strobes, byte enables, peripheral
// direct transfer and hold/acknowledge arbitration.
// Assumes straps and pin inputs are asynchronous; register port on clk.
//
// The strobed register port and the register addresses were chosen for this implementation.

`timescale 1ns/100ps
`default_nettype none

// Function
// - At reset two address strap pins pick the interface clock: pin clock, core/4 or core/6.
// - The divided output clock is the interface clock divided by one, two or four.
// - The full-rate output clock follows the interface clock with no division.
// - Strobe A is async read enable, SDRAM column strobe or sync address/read strobe by type.
// - Strobe B is async output enable, SDRAM row strobe or sync output enable by memory type.
// - For sync memory with read-enable-select at 0, strobe A acts as the address strobe.
// - For sync memory with read-enable-select at 1, strobe A acts as the read enable.
// - Byte enables are decoded from the low address bit and size, by memory width.
// - Byte enables mark the addressed lanes on reads and writes alike, so only addressed lanes are written.
// - A peripheral direct transfer output marks transfers between two external peripherals.
// - A host raises hold request and the device raises hold acknowledge once it yields the bus.
// - A bus request output shows that the device needs the external bus.
module narrow_ext_mem_pin_control
  import mem_pin_pkg::*;
(
  input wire logic clk, // Core clock, 200 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [3:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic ext_mem_clock_in, // External interface clock pin
  input wire logic [1:0] ext_addr_pins, // Strap levels of address pins 15:14
  output logic mem_clock_out_full, // Full-rate output clock
  output logic mem_clock_out_full_oe, // Drive enable
  output logic mem_clock_out_div, // Divided output clock
  output logic mem_clock_out_div_oe, // Drive enable
  output logic read_col_strobe_n, // Shared strobe A, active low
  output logic read_col_strobe_oe, // Drive enable
  output logic out_row_strobe_n, // Shared strobe B, active low
  output logic out_row_strobe_oe, // Drive enable
  output logic byte_lane_enable_lo_n, // Low lane enable, active low
  output logic byte_lane_enable_hi_n, // High lane enable, active low
  output logic byte_lane_enable_oe, // Drive enable for both lanes
  output logic peripheral_direct_xfer_n, // Direct transfer, active low
  output logic peripheral_direct_xfer_oe, // Drive enable
  input wire logic hold_request_in, // Host hold request, active high
  output logic hold_ack_out, // Hold acknowledge, active high
  output logic bus_request_out // Device needs the bus, active high
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_cnt;
    logic strap_done;
    clk_src_t clk_sel;
    logic ext_s1;
    logic ext_s2;
    logic hold_s1;
    logic hold_s2;
    logic [2:0] ph;
    logic full_clk;
    logic [1:0] div_cnt;
    logic div_clk;
    logic [CFG_W-1:0] cfg;
    logic [CMD_W-1:0] cmd;
    logic pending;
    logic [CMD_W-1:0] act;
    acc_state_t state;
    logic [1:0] cnt;
    logic hold_ack;
    logic strobe_a_n;
    logic strobe_b_n;
    logic be_lo_n;
    logic be_hi_n;
    logic pdt_n;
    logic pins_oe;
    logic bus_req;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic full_lvl;
  logic tick;
  logic active;
  logic first;
  logic is_read;
  logic a_on;
  logic b_on;
  logic lo_on;
  logic hi_on;
  logic [STAT_W-1:0] status;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    full_lvl = s_reg.full_clk;
    tick = 1'b0;
    active = 1'b0;
    first = 1'b0;
    is_read = 1'b0;
    a_on = 1'b0;
    b_on = 1'b0;
    lo_on = 1'b0;
    hi_on = 1'b0;
    status = {s_reg.strap_done, s_reg.clk_sel, s_reg.hold_ack, s_reg.pending,
              (s_reg.state != ACC_IDLE)};

    // Two-stage synchronisers; first stages feed nothing else
    s_next.strap_s1 = ext_addr_pins;
    s_next.strap_s2 = s_reg.strap_s1;
    s_next.ext_s1 = ext_mem_clock_in;
    s_next.ext_s2 = s_reg.ext_s1;
    s_next.hold_s1 = hold_request_in;
    s_next.hold_s2 = s_reg.hold_s1;

    // Straps caught once, after the synchroniser has settled
    if (!s_reg.strap_done) begin
      s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      if (s_reg.strap_cnt == STRAP_SETTLE) begin
        s_next.strap_done = 1'b1;
        if (s_reg.strap_s2 == SRC_DIV4) begin
          s_next.clk_sel = SRC_DIV4;
        end else if (s_reg.strap_s2 == SRC_DIV6) begin
          s_next.clk_sel = SRC_DIV6;
        end else begin
          s_next.clk_sel = SRC_EXT;
        end
      end
    end

    // ----------------------------------------------------------------
    // Interface clock, as a level and a rising-edge tick
    // ----------------------------------------------------------------
    if (s_reg.strap_done) begin
      case (s_reg.clk_sel)
        SRC_DIV4: begin
          s_next.ph = (s_reg.ph >= DIV4_LAST) ? 3'h0 : s_reg.ph + 3'h1;
          full_lvl = (s_next.ph < DIV4_HIGH);
        end
        SRC_DIV6: begin
          s_next.ph = (s_reg.ph >= DIV6_LAST) ? 3'h0 : s_reg.ph + 3'h1;
          full_lvl = (s_next.ph < DIV6_HIGH);
        end
        default: begin
          full_lvl = s_reg.ext_s2;
        end
      endcase
    end
    // Full-rate clock is the interface clock itself
    s_next.full_clk = full_lvl;
    tick = full_lvl && !s_reg.full_clk;

    // Divided clock; ratio change takes effect at the next rising tick, or for divide by one as soon as both clocks are at the same level
    if (tick) begin
      s_next.div_cnt = s_reg.div_cnt + 2'h1;
    end
    case (div_ratio_t'(s_reg.cfg[CFG_DIV_MSB:CFG_DIV_LSB]))
      DIV_BY2: begin
        if (tick) begin
          s_next.div_clk = ~s_reg.div_clk;
        end
      end
      DIV_BY4: begin
        if (tick && s_reg.div_cnt[0]) begin
          s_next.div_clk = ~s_reg.div_clk;
        end
      end
      default: begin
        s_next.div_clk = (tick || s_reg.div_clk == s_reg.full_clk) ? full_lvl
          : s_reg.div_clk;
      end
    endcase

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    s_next.rdata = 32'h0;
    if (reg_wr) begin
      if (reg_addr == CFG_ADDR) begin
        s_next.cfg = reg_wdata[CFG_W-1:0];
      end else if (reg_addr == CMD_ADDR) begin
        // One pending slot; a command while one waits is dropped
        if (!s_reg.pending) begin
          s_next.pending = 1'b1;
          s_next.cmd = reg_wdata[CMD_W-1:0];
        end
      end
    end
    if (reg_rd) begin
      if (reg_addr == CFG_ADDR) begin
        s_next.rdata = {{(32-CFG_W){1'b0}}, s_reg.cfg};
      end else if (reg_addr == CMD_ADDR) begin
        s_next.rdata = {{(32-CMD_W){1'b0}}, s_reg.cmd};
      end else if (reg_addr == STATUS_ADDR) begin
        s_next.rdata = {{(32-STAT_W){1'b0}}, status};
      end else begin
        s_next.rdata = 32'h0;
      end
    end

    // ----------------------------------------------------------------
    // Arbitration: the host wins whenever the sequencer is idle
    // ----------------------------------------------------------------
    if (!s_reg.hold_s2) begin
      s_next.hold_ack = 1'b0;
    end else if (s_reg.state == ACC_IDLE) begin
      s_next.hold_ack = 1'b1;
    end

    // ----------------------------------------------------------------
    // Access sequencer, stepped on interface clock ticks
    // ----------------------------------------------------------------
    case (s_reg.state)
      ACC_IDLE: begin
        if (tick && s_reg.pending && !s_reg.hold_ack && !s_reg.hold_s2) begin
          s_next.state = ACC_STROBE;
          s_next.cnt = STROBE_TICKS - 2'h1;
          s_next.act = s_reg.cmd;
          s_next.pending = 1'b0;
        end
      end
      ACC_STROBE: begin
        if (tick) begin
          if (s_reg.cnt == 2'h0) begin
            s_next.state = ACC_RECOVER;
          end else begin
            s_next.cnt = s_reg.cnt - 2'h1;
          end
        end
      end
      ACC_RECOVER: begin
        if (tick) begin
          s_next.state = ACC_IDLE;
        end
      end
      default: begin
        s_next.state = ACC_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Pin decode, registered so pins come straight from flops
    // ----------------------------------------------------------------
    active = (s_next.state == ACC_STROBE);
    first = active && (s_next.cnt == STROBE_TICKS - 2'h1);
    is_read = !s_next.act[CMD_WRITE_BIT];
    case (mem_type_t'(s_reg.cfg[CFG_TYPE_MSB:CFG_TYPE_LSB]))
      MT_SDRAM: begin
        a_on = active && s_next.act[CMD_COL_BIT];
        b_on = active && !s_next.act[CMD_COL_BIT];
      end
      MT_SYNC: begin
        if (s_reg.cfg[CFG_RSEL_BIT]) begin
          a_on = active && is_read;
        end else begin
          a_on = first;
        end
        b_on = active && is_read;
      end
      default: begin
        a_on = active && is_read;
        b_on = active && is_read;
      end
    endcase

    // Narrow memory uses the low lane only; the high lane stays idle
    if (!s_reg.cfg[CFG_WIDE_BIT]) begin
      lo_on = active;
    end else if (s_next.act[CMD_HALF_BIT]) begin
      lo_on = active;
      hi_on = active;
    end else begin
      lo_on = active && !s_next.act[CMD_A0_BIT];
      hi_on = active && s_next.act[CMD_A0_BIT];
    end

    s_next.strobe_a_n = !a_on;
    s_next.strobe_b_n = !b_on;
    s_next.be_lo_n = !lo_on;
    s_next.be_hi_n = !hi_on;
    s_next.pdt_n = !(active && s_next.act[CMD_PDT_BIT]);
    s_next.pins_oe = !s_next.hold_ack;
    s_next.bus_req = s_next.pending || (s_next.state != ACC_IDLE);
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.clk_sel <= SRC_EXT;
      s_reg.cfg <= CFG_RESET;
      s_reg.cmd <= CMD_RESET;
      s_reg.act <= CMD_RESET;
      s_reg.state <= ACC_IDLE;
      s_reg.strobe_a_n <= 1'b1;
      s_reg.strobe_b_n <= 1'b1;
      s_reg.be_lo_n <= 1'b1;
      s_reg.be_hi_n <= 1'b1;
      s_reg.pdt_n <= 1'b1;
      s_reg.pins_oe <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign reg_rdata = s_reg.rdata;
  assign mem_clock_out_full = s_reg.full_clk;
  assign mem_clock_out_full_oe = s_reg.pins_oe;
  assign mem_clock_out_div = s_reg.div_clk;
  assign mem_clock_out_div_oe = s_reg.pins_oe;
  assign read_col_strobe_n = s_reg.strobe_a_n;
  assign read_col_strobe_oe = s_reg.pins_oe;
  assign out_row_strobe_n = s_reg.strobe_b_n;
  assign out_row_strobe_oe = s_reg.pins_oe;
  assign byte_lane_enable_lo_n = s_reg.be_lo_n;
  assign byte_lane_enable_hi_n = s_reg.be_hi_n;
  assign byte_lane_enable_oe = s_reg.pins_oe;
  assign peripheral_direct_xfer_n = s_reg.pdt_n;
  assign peripheral_direct_xfer_oe = s_reg.pins_oe;
  assign hold_ack_out = s_reg.hold_ack;
  assign bus_request_out = s_reg.bus_req;

endmodule

`default_nettype wire

//--- mem_pin_assertions.sv
// Checker for the narrow memory pin control, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module mem_pin_assertions
  import mem_pin_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic mem_clock_out_full,
  input wire logic mem_clock_out_full_oe,
  input wire logic mem_clock_out_div,
  input wire logic mem_clock_out_div_oe,
  input wire logic read_col_strobe_n,
  input wire logic read_col_strobe_oe,
  input wire logic out_row_strobe_n,
  input wire logic out_row_strobe_oe,
  input wire logic byte_lane_enable_lo_n,
  input wire logic byte_lane_enable_hi_n,
  input wire logic byte_lane_enable_oe,
  input wire logic peripheral_direct_xfer_n,
  input wire logic peripheral_direct_xfer_oe,
  input wire logic hold_request_in,
  input wire logic hold_ack_out,
  input wire logic bus_request_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------------
  // Access steps
  // ------------------------------------------------------------------
  // Idle device: a command write is never refused
  sequence s_cmd_taken;
    reg_wr && reg_addr == CMD_ADDR && !bus_request_out;
  endsequence
  sequence s_lane_start;
    $fell(byte_lane_enable_lo_n) || $fell(byte_lane_enable_hi_n);
  endsequence
  wire logic quiet = &{read_col_strobe_n, out_row_strobe_n, byte_lane_enable_lo_n,
    byte_lane_enable_hi_n, peripheral_direct_xfer_n};
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  a_cmd_raises_req: assert property (s_cmd_taken |=> bus_request_out)
    else $error("bus request missing after command");
  a_lane_on_tick: assert property (s_lane_start |-> $rose(mem_clock_out_full))
    else $error("byte lanes start off the clock edge");
  a_idle_quiet: assert property (!bus_request_out |-> quiet)
    else $error("strobe active with no bus need");
  a_div_follows: assert property ($changed(mem_clock_out_div) |->
    $changed(mem_clock_out_full))
    else $error("divided clock moved off a full clock edge");
  a_oe_vs_ack: assert property ({mem_clock_out_full_oe, mem_clock_out_div_oe,
    read_col_strobe_oe, out_row_strobe_oe, byte_lane_enable_oe,
    peripheral_direct_xfer_oe} == {6{!hold_ack_out}})
    else $error("drive enables disagree with hold ack");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_ack_needs_req: assert property ($rose(hold_ack_out) |-> $past(hold_request_in, 3))
    else $error("hold ack without request");
  a_ack_drops: assert property (!hold_request_in [*5] |-> !hold_ack_out)
    else $error("hold ack kept after request dropped");
  a_ack_no_access: assert property (hold_ack_out |-> quiet)
    else $error("access while bus yielded");
endmodule
bind narrow_ext_mem_pin_control mem_pin_assertions mem_pin_assertions_inst (.clk, .rst,
  .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .mem_clock_out_full, .mem_clock_out_full_oe,
  .mem_clock_out_div, .mem_clock_out_div_oe, .read_col_strobe_n, .read_col_strobe_oe,
  .out_row_strobe_n, .out_row_strobe_oe, .byte_lane_enable_lo_n, .byte_lane_enable_hi_n,
  .byte_lane_enable_oe, .peripheral_direct_xfer_n, .peripheral_direct_xfer_oe,
  .hold_request_in, .hold_ack_out, .bus_request_out);
`default_nettype wire

//--- ext_side.sv
// Far side model: bus-requesting host, pin clock source and pin pulls.
// Assumes pins packed as {full, div, strobe a, strobe b, lo, hi, direct}.
`timescale 1ns/100ps
`default_nettype none
module ext_side (
  input wire logic clk, // Core clock
  input wire logic host_wants, // Bench asks for the bus
  input wire logic hold_ack_out, // Device yielded
  input wire logic [6:0] pin_out, // Device pin values
  input wire logic [6:0] pin_oe, // Device drive enables
  output logic hold_request_in, // Host request
  output logic ext_mem_clock_in, // Free-running pin clock
  output logic [6:0] pin_lvl // Resolved wire levels
);
  // Clocks pulled down, strobes pulled up
  localparam logic [6:0] PULL = 7'h1f;
  logic [1:0] tick_cnt = 2'h0;
  initial hold_request_in = 1'b0;
  initial ext_mem_clock_in = 1'b0;
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    if (tick_cnt == 2'h3) ext_mem_clock_in <= !ext_mem_clock_in;
    hold_request_in <= host_wants;
  end
  // Released pins settle to their pull level, never to a stale value
  always_comb begin
    for (int i = 0; i < 7; i++) pin_lvl[i] = pin_oe[i] ? pin_out[i] : PULL[i];
  end
endmodule
`default_nettype wire

//--- narrow_ext_mem_pin_control_tb.sv
// Self-checking bench for the narrow memory pin control.
// Assumes strap 01 (core/4) at first, then a second reset with strap 10 and a third with strap 00.
`timescale 1ns/100ps
`default_nettype none
module narrow_ext_mem_pin_control_tb;
  import mem_pin_pkg::*;
  logic clk, rst, reg_wr, reg_rd, ext_mem_clock_in, hold_request_in, host_wants;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [1:0] ext_addr_pins;
  logic mem_clock_out_full, mem_clock_out_full_oe, mem_clock_out_div, mem_clock_out_div_oe;
  logic read_col_strobe_n, read_col_strobe_oe, out_row_strobe_n, out_row_strobe_oe;
  logic byte_lane_enable_lo_n, byte_lane_enable_hi_n, byte_lane_enable_oe;
  logic peripheral_direct_xfer_n, peripheral_direct_xfer_oe, hold_ack_out, bus_request_out;
  logic [6:0] pin_lvl;
  int num_errors = 0;
  int tests_run = 0;
  int n, p;
  narrow_ext_mem_pin_control narrow_ext_mem_pin_control_inst (.clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_mem_clock_in, .ext_addr_pins,
    .mem_clock_out_full, .mem_clock_out_full_oe, .mem_clock_out_div, .mem_clock_out_div_oe,
    .read_col_strobe_n, .read_col_strobe_oe, .out_row_strobe_n, .out_row_strobe_oe,
    .byte_lane_enable_lo_n, .byte_lane_enable_hi_n, .byte_lane_enable_oe,
    .peripheral_direct_xfer_n, .peripheral_direct_xfer_oe, .hold_request_in, .hold_ack_out,
    .bus_request_out);
  ext_side ext_side_inst (.clk, .host_wants, .hold_ack_out, .hold_request_in,
    .ext_mem_clock_in, .pin_lvl, .pin_out({mem_clock_out_full, mem_clock_out_div,
    read_col_strobe_n, out_row_strobe_n, byte_lane_enable_lo_n, byte_lane_enable_hi_n,
    peripheral_direct_xfer_n}), .pin_oe({mem_clock_out_full_oe, mem_clock_out_div_oe,
    read_col_strobe_oe, out_row_strobe_oe, byte_lane_enable_oe, byte_lane_enable_oe,
    peripheral_direct_xfer_oe}));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask
  function automatic logic sig(int s);
    case (s)
      0: return mem_clock_out_full;
      1: return mem_clock_out_div;
      2: return byte_lane_enable_lo_n & byte_lane_enable_hi_n;
      3: return hold_ack_out;
      default: return bus_request_out;
    endcase
  endfunction
  // Bounded wait; n is left holding the cycles spent
  task automatic waitfor(int s, logic v);
    n = 0;
    while (sig(s) !== v && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("wait", 32'(n < 200), 32'h1);
  endtask
  task automatic per(int s);
    waitfor(s, 1'b0);
    waitfor(s, 1'b1);
    waitfor(s, 1'b0);
    p = n;
    waitfor(s, 1'b1);
    p += n;
  endtask
  // Expected pins {strobe a, strobe b, lo, hi, direct}; lanes held 2 ticks of 4 clk
  task automatic acc(logic [5:0] cfg, logic [4:0] cmd, logic [4:0] exp);
    wr(CFG_ADDR, 32'(cfg));
    wr(CMD_ADDR, 32'(cmd));
    @(negedge clk);
    chk("bus_req", 32'(bus_request_out), 32'h1);
    waitfor(2, 1'b0);
    chk("strobes", 32'({read_col_strobe_n, out_row_strobe_n, byte_lane_enable_lo_n,
      byte_lane_enable_hi_n, peripheral_direct_xfer_n}), 32'(exp));
    waitfor(2, 1'b1);
    chk("lane_len", n, 8);
    waitfor(4, 1'b0);
  endtask
  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
  initial begin
    {rst, reg_wr, reg_rd, host_wants} = 4'hf - 4'h7;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ext_addr_pins = 2'h1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("rdata_rst", reg_rdata, 32'h0);
    chk("ack_rst", 32'({hold_ack_out, bus_request_out}), 32'h0);
    rd(CFG_ADDR);
    chk("cfg_rst", rv, 32'h0);
    wr(CFG_ADDR, 32'hffff_ffff);
    rd(CFG_ADDR);
    chk("cfg_rw", rv, 32'h3f);
    rd(4'hc);
    chk("unmapped", rv, 32'h0);
    rd(STATUS_ADDR);
    chk("status", rv, 32'h28);
    for (int d = 0; d < 3; d++) begin
      wr(CFG_ADDR, 32'(d));
      repeat (20) @(negedge clk);
      per(0);
      chk("full_per", p, 4);
      per(1);
      chk("div_per", p, 4 << d);
    end
    acc(6'h04, 5'h04, 5'h01);
    acc(6'h00, 5'h11, 5'h1a);
    acc(6'h0c, 5'h0a, 5'h0d);
    acc(6'h0c, 5'h05, 5'h11);
    acc(6'h34, 5'h00, 5'h03);
    acc(6'h14, 5'h01, 5'h0b);
    acc(6'h34, 5'h01, 5'h1b);
    @(posedge clk);
    host_wants <= 1'b1;
    waitfor(3, 1'b1);
    wr(CMD_ADDR, 32'h4);
    repeat (20) @(negedge clk);
    chk("pins_held", 32'(pin_lvl), 32'h1f);
    chk("req_in_hold", 32'(bus_request_out), 32'h1);
    @(posedge clk);
    host_wants <= 1'b0;
    waitfor(3, 1'b0);
    waitfor(2, 1'b0);
    waitfor(4, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    ext_addr_pins <= 2'h2;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(negedge clk);
    rd(STATUS_ADDR);
    chk("status6", rv, 32'h30);
    per(0);
    chk("full6", p, 6);
    // Strap 00: interface clock comes from the pin clock of the far side
    @(posedge clk);
    rst <= 1'b1;
    ext_addr_pins <= 2'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(negedge clk);
    rd(STATUS_ADDR);
    chk("status_ext", rv, 32'h20);
    per(0);
    chk("full_ext", p, 8);
    close_out();
  end
endmodule
`default_nettype wire
